// *** pmtm_pkg.sv ***
// Package for the MAC-facing data port: mode straps, widths and clock divider counts.
// Assumes a 40 MHz system clock on both ends.
package pmtm_pkg;
    localparam logic [2:0] PMTM_SEL_MII     = 3'h0;
    localparam logic [2:0] PMTM_SEL_TBI     = 3'h1;
    localparam logic [2:0] PMTM_SEL_MII_ALT = 3'h2;
    localparam int         PMTM_NIB_W       = 4;
    localparam int         PMTM_BUS_W       = 10;
    localparam int         PMTM_FIFO_DEPTH  = 8;
    localparam int         PMTM_CLK_KHZ     = 40000;
    localparam int         PMTM_MII100_KHZ  = 25000;
    localparam int         PMTM_MII10_KHZ   = 2500;
    localparam int         PMTM_TBI_TX_KHZ  = 125000;
    localparam int         PMTM_TBI_RX_KHZ  = 62500;
    // Half periods in system cycles, at least one.
    localparam int         PMTM_HALF_100    = (PMTM_CLK_KHZ / (2 * PMTM_MII100_KHZ)) < 1 ? 1
                                            : PMTM_CLK_KHZ / (2 * PMTM_MII100_KHZ);
    localparam int         PMTM_HALF_10     = PMTM_CLK_KHZ / (2 * PMTM_MII10_KHZ);
    localparam int         PMTM_HALF_TBI    = 1;
    localparam logic [7:0] PMTM_K28_POS     = 8'h7c;
    localparam logic [6:0] PMTM_COMMA_PAT   = 7'h1f;

    typedef enum logic [1:0] {PMTM_MODE_MII, PMTM_MODE_ALT, PMTM_MODE_TBI, PMTM_MODE_OFF} pmtm_mode_t;

    function automatic pmtm_mode_t pmtm_decode(input logic [2:0] sel);
        case (sel)
            PMTM_SEL_MII:     pmtm_decode = PMTM_MODE_MII;
            PMTM_SEL_MII_ALT: pmtm_decode = PMTM_MODE_ALT;
            PMTM_SEL_TBI:     pmtm_decode = PMTM_MODE_TBI;
            default:          pmtm_decode = PMTM_MODE_OFF;
        endcase
    endfunction : pmtm_decode

    // Comma is the 7-bit pattern 0011111 or its complement at the group head.
    function automatic logic pmtm_is_comma(input logic [9:0] grp);
        pmtm_is_comma = (grp[9:3] == PMTM_COMMA_PAT) || (grp[9:3] == ~PMTM_COMMA_PAT);
    endfunction : pmtm_is_comma
endpackage : pmtm_pkg

// *** pmtm_if.sv ***
// Interface carrying the port pins between the transceiver end and the MAC end.
// Assumes the bench joins both ends; all pins are one-way.
`timescale 1ns/10ps
interface pmtm_if;
    logic       tx_clk;
    logic       gtx_clk;
    logic       tx_en;
    logic       tx_er;
    logic [9:0] txd;
    logic       rx_clk0;
    logic       rx_clk1;
    logic       rx_dv;
    logic       rx_er;
    logic [9:0] rxd;
    logic       crs_comma;
    logic       col;

    modport dev (input gtx_clk, tx_en, tx_er, txd,
                 output tx_clk, rx_clk0, rx_clk1, rx_dv, rx_er, rxd, crs_comma, col);
    modport mac (output gtx_clk, tx_en, tx_er, txd,
                 input tx_clk, rx_clk0, rx_clk1, rx_dv, rx_er, rxd, crs_comma, col);
endinterface : pmtm_if

// *** pmtm_fifo.sv ***
// FIFO with valid/ready on both sides, width and depth as parameters.
// Assumes a single clock; depth is a power of two.
`timescale 1ns/10ps
module pmtm_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 8
) (
    // Clock and control.
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    input  wire logic             ce_in,
    // Fill side.
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side.
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_reg;
    logic [AW:0]      rd_reg;
    logic             push;
    logic             pop;

    assign in_ready_out  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
    assign out_valid_out = wr_reg != rd_reg;
    assign out_data_out  = mem[rd_reg[AW-1:0]];
    assign push          = ce_in && in_valid_in && in_ready_out;
    assign pop           = ce_in && out_valid_out && out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule : pmtm_fifo

// *** pmtm_dev.sv ***
// Transceiver end of the MAC data port: MII, alternate MII and ten-bit modes.
// Assumes the line side is a plain user port on the system clock and straps are static.
`timescale 1ns/10ps
module pmtm_dev
    import pmtm_pkg::*;
#(
    parameter int FIFO_DEPTH = PMTM_FIFO_DEPTH
) (
    // Clock, reset and enable.
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic       ce_in,
    // Static configuration.
    input  wire logic [2:0] interface_select_straps_in,
    input  wire logic       speed_100_in,
    input  wire logic       half_duplex_in,
    input  wire logic       crs_on_tx_in,
    // Line side receive.
    input  wire logic       line_rx_valid_in,
    input  wire logic       line_rx_err_in,
    input  wire logic [9:0] line_rx_data_in,
    input  wire logic       line_rx_busy_in,
    output logic            line_rx_ready_out,
    // Line side transmit and caught mode.
    output logic            line_tx_valid_out,
    output logic            line_tx_err_out,
    output logic [9:0]      line_tx_data_out,
    input  wire logic       line_tx_ready_in,
    output logic            line_tx_busy_out,
    output logic [1:0]      mode_out,
    // MAC pins.
    pmtm_if.dev             port
);
    pmtm_mode_t mode_reg;
    logic       strap_done_reg;
    logic [9:0] div_reg;
    logic       clk_gen_reg;
    logic       tick_rise;
    logic [2:0] gtx_sync_reg;
    logic       gtx_rise;
    logic       tx_clk_reg, rx_clk0_reg, rx_clk1_reg, rx_dv_reg, rx_er_reg, crs_reg, col_reg;
    logic [9:0] rxd_reg;
    logic [1:0] ctl_s1_reg, ctl_s2_reg;
    logic [9:0] txd_s1_reg, txd_s2_reg;
    logic       fifo_valid;
    logic [5:0] fifo_data;
    logic       push_valid;
    logic       tx_busy_reg;
    logic       fifo_pop;

    // Straps are captured once after reset release and held thereafter.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            strap_done_reg <= 1'b0;
            mode_reg       <= PMTM_MODE_OFF;
        end else if (ce_in && !strap_done_reg) begin
            strap_done_reg <= 1'b1;
            mode_reg       <= pmtm_decode(interface_select_straps_in);
        end
    end
    assign mode_out = mode_reg;

    // Divider for nibble and ten-bit receive clocks.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            div_reg     <= '0;
            clk_gen_reg <= 1'b0;
        end else if (ce_in) begin
            if (div_reg + 10'h1 >= 10'((mode_reg == PMTM_MODE_TBI) ? PMTM_HALF_TBI
                                       : speed_100_in ? PMTM_HALF_100 : PMTM_HALF_10)) begin
                div_reg     <= '0;
                clk_gen_reg <= ~clk_gen_reg;
            end else begin
                div_reg <= div_reg + 10'h1;
            end
        end
    end
    assign tick_rise = ce_in && (div_reg + 10'h1 >= 10'((mode_reg == PMTM_MODE_TBI) ? PMTM_HALF_TBI
                                 : speed_100_in ? PMTM_HALF_100 : PMTM_HALF_10)) && !clk_gen_reg;

    // Pin inputs pass two flops before use.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            gtx_sync_reg <= '0;
            ctl_s1_reg   <= '0;
            ctl_s2_reg   <= '0;
            txd_s1_reg   <= '0;
            txd_s2_reg   <= '0;
        end else if (ce_in) begin
            gtx_sync_reg <= {gtx_sync_reg[1:0], port.gtx_clk};
            ctl_s1_reg   <= {port.tx_er, port.tx_en};
            ctl_s2_reg   <= ctl_s1_reg;
            txd_s1_reg   <= port.txd;
            txd_s2_reg   <= txd_s1_reg;
        end
    end
    assign gtx_rise = gtx_sync_reg[2:1] == 2'b01;

    // Transmit samples: generated clock in standard mode, MAC clock in alternate and ten-bit modes.
    always_comb begin
        case (mode_reg)
            PMTM_MODE_MII: push_valid = tick_rise && ctl_s2_reg[0];
            PMTM_MODE_ALT: push_valid = ce_in && gtx_rise && ctl_s2_reg[0];
            PMTM_MODE_TBI: push_valid = ce_in && gtx_rise;
            default:       push_valid = 1'b0;
        endcase
    end

    pmtm_fifo #(.WIDTH(6), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in        (clk_in),
        .resetn_in     (resetn_in),
        .ce_in         (ce_in),
        .in_valid_in   (push_valid),
        .in_ready_out  (),
        .in_data_in    ({ctl_s2_reg[1], ctl_s2_reg[0], txd_s2_reg[3:0]}),
        .out_valid_out (fifo_valid),
        .out_ready_in  (line_tx_ready_in),
        .out_data_out  (fifo_data)
    );
    assign fifo_pop = mode_reg != PMTM_MODE_TBI;

    // Line transmit outputs; ten-bit groups bypass the nibble FIFO.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            line_tx_valid_out <= 1'b0;
            line_tx_err_out   <= 1'b0;
            line_tx_data_out  <= '0;
            tx_busy_reg       <= 1'b0;
        end else if (ce_in) begin
            if (mode_reg == PMTM_MODE_TBI) begin
                line_tx_valid_out <= push_valid;
                line_tx_err_out   <= 1'b0;
                line_tx_data_out  <= txd_s2_reg;
            end else begin
                line_tx_valid_out <= fifo_valid && line_tx_ready_in && fifo_pop;
                line_tx_err_out   <= fifo_valid && fifo_data[5];
                line_tx_data_out  <= {6'h00, fifo_data[3:0]};
            end
            tx_busy_reg <= ctl_s2_reg[0] || fifo_valid;
        end
    end
    assign line_tx_busy_out  = tx_busy_reg;
    assign line_rx_ready_out = (mode_reg == PMTM_MODE_TBI) ? (ce_in && tick_rise)
                                                           : (ce_in && tick_rise && clk_gen_reg == 1'b0);

    // Clock and receive outputs toward the MAC, all registered.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            tx_clk_reg  <= 1'b0;
            rx_clk0_reg <= 1'b0;
            rx_clk1_reg <= 1'b1;
            rx_dv_reg   <= 1'b0;
            rx_er_reg   <= 1'b0;
            rxd_reg     <= '0;
            crs_reg     <= 1'b0;
            col_reg     <= 1'b0;
        end else if (ce_in) begin
            tx_clk_reg  <= (mode_reg == PMTM_MODE_MII) && clk_gen_reg;
            rx_clk0_reg <= (mode_reg != PMTM_MODE_OFF) && clk_gen_reg;
            rx_clk1_reg <= (mode_reg == PMTM_MODE_TBI) && !clk_gen_reg;
            if (line_rx_ready_out) begin
                if (mode_reg == PMTM_MODE_TBI) begin
                    rxd_reg   <= line_rx_data_in;
                    crs_reg   <= pmtm_is_comma(line_rx_data_in);
                    rx_dv_reg <= 1'b0;
                    rx_er_reg <= 1'b0;
                    col_reg   <= 1'b0;
                end else begin
                    rxd_reg   <= {6'h00, line_rx_valid_in ? line_rx_data_in[3:0] : 4'h0};
                    rx_dv_reg <= line_rx_valid_in;
                    rx_er_reg <= line_rx_valid_in && line_rx_err_in;
                    crs_reg   <= line_rx_busy_in
                                 || (half_duplex_in && crs_on_tx_in && tx_busy_reg);
                    col_reg   <= half_duplex_in && line_rx_busy_in && tx_busy_reg;
                end
            end
        end
    end

    assign port.tx_clk    = tx_clk_reg;
    assign port.rx_clk0   = rx_clk0_reg;
    assign port.rx_clk1   = rx_clk1_reg;
    assign port.rx_dv     = rx_dv_reg;
    assign port.rx_er     = rx_er_reg;
    assign port.rxd       = rxd_reg;
    assign port.crs_comma = crs_reg;
    assign port.col       = col_reg;
endmodule : pmtm_dev

// *** pmtm_mac.sv ***
// MAC end of the data port: drives transmit pins and samples receive pins.
// Assumes the same strap value as the transceiver, given as a static input.
`timescale 1ns/10ps
module pmtm_mac
    import pmtm_pkg::*;
(
    // Clock, reset, enable and static configuration.
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic       ce_in,
    input  wire logic [2:0] interface_select_straps_in,
    input  wire logic       speed_100_in,
    input  wire logic       gig_link_in,
    // User transmit side.
    input  wire logic       tx_valid_in,
    input  wire logic       tx_err_in,
    input  wire logic [9:0] tx_data_in,
    output logic            tx_ready_out,
    // User receive side.
    output logic            rx_valid_out,
    output logic            rx_err_out,
    output logic [9:0]      rx_data_out,
    output logic            crs_out,
    output logic            col_out,
    // Port pins.
    pmtm_if.mac             port
);
    pmtm_mode_t mode_reg;
    logic [9:0] div_reg;
    logic       gclk_reg;
    logic       wrap;
    logic [2:0] tclk_sync_reg;
    logic [1:0] r0_sync_reg;
    logic [2:0] r0_edge_reg;
    logic [9:0] rxd_s1_reg, rxd_s2_reg;
    logic [3:0] st_s1_reg, st_s2_reg;
    logic       tx_en_reg, tx_er_reg;
    logic [9:0] txd_reg;
    logic       load;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            mode_reg <= PMTM_MODE_OFF;
        end else if (ce_in) begin
            mode_reg <= pmtm_decode(interface_select_straps_in);
        end
    end

    // Clock this end makes: alternate nibble clock, or ten-bit clock when gig_link_in is set, low otherwise.
    assign wrap = div_reg + 10'h1 >= 10'((mode_reg == PMTM_MODE_TBI) ? PMTM_HALF_TBI
                                         : speed_100_in ? PMTM_HALF_100 : PMTM_HALF_10);
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            div_reg  <= '0;
            gclk_reg <= 1'b0;
        end else if (ce_in) begin
            div_reg <= wrap ? 10'h0 : div_reg + 10'h1;
            if (mode_reg == PMTM_MODE_ALT || (mode_reg == PMTM_MODE_TBI && gig_link_in)) begin
                gclk_reg <= wrap ? ~gclk_reg : gclk_reg;
            end else begin
                gclk_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            tclk_sync_reg <= '0;
            r0_sync_reg   <= '0;
            r0_edge_reg   <= '0;
            rxd_s1_reg    <= '0;
            rxd_s2_reg    <= '0;
            st_s1_reg     <= '0;
            st_s2_reg     <= '0;
        end else if (ce_in) begin
            tclk_sync_reg <= {tclk_sync_reg[1:0], port.tx_clk};
            r0_edge_reg   <= {r0_edge_reg[1:0], port.rx_clk0};
            r0_sync_reg   <= r0_edge_reg[2:1];
            rxd_s1_reg    <= port.rxd;
            rxd_s2_reg    <= rxd_s1_reg;
            st_s1_reg     <= {port.rx_dv, port.rx_er, port.crs_comma, port.col};
            st_s2_reg     <= st_s1_reg;
        end
    end

    // New transmit word at the falling edge of the active clock.
    always_comb begin
        case (mode_reg)
            PMTM_MODE_MII: load = tclk_sync_reg[2:1] == 2'b10;
            PMTM_MODE_ALT: load = wrap && gclk_reg;
            PMTM_MODE_TBI: load = wrap && gclk_reg;
            default:       load = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            tx_en_reg <= 1'b0;
            tx_er_reg <= 1'b0;
            txd_reg   <= '0;
        end else if (ce_in) begin
            if (load) begin
                tx_en_reg <= tx_valid_in;
                tx_er_reg <= tx_valid_in && tx_err_in;
                txd_reg   <= (mode_reg == PMTM_MODE_TBI) ? tx_data_in
                             : {6'h00, tx_data_in[3:0]};
            end
        end
    end
    assign tx_ready_out = ce_in && load;

    // Receive pins after two flops, registered every cycle; valid pulses on a rising receive clock.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rx_valid_out <= 1'b0;
            rx_err_out   <= 1'b0;
            rx_data_out  <= '0;
            crs_out      <= 1'b0;
            col_out      <= 1'b0;
        end else if (ce_in) begin
            rx_valid_out <= r0_sync_reg == 2'b01 && (mode_reg == PMTM_MODE_TBI || st_s2_reg[3]);
            rx_err_out   <= st_s2_reg[2];
            rx_data_out  <= rxd_s2_reg;
            crs_out      <= st_s2_reg[1];
            col_out      <= st_s2_reg[0];
        end
    end

    assign port.gtx_clk = gclk_reg;
    assign port.tx_en   = tx_en_reg;
    assign port.tx_er   = tx_er_reg;
    assign port.txd     = txd_reg;
endmodule : pmtm_mac

// *** pmtm_properties.sv ***
// Checker on the port pins between the transceiver end and the MAC end.
// Assumes static straps and one system clock shared by both ends.
`timescale 1ns/10ps
module pmtm_props
    import pmtm_pkg::*;
(
    // Clock, reset and straps.
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic [2:0] interface_select_straps_in,
    // Port pins.
    input  wire logic       tx_clk,
    input  wire logic       gtx_clk,
    input  wire logic       tx_en,
    input  wire logic       tx_er,
    input  wire logic [9:0] txd,
    input  wire logic       rx_clk0,
    input  wire logic       rx_clk1,
    input  wire logic       rx_dv,
    input  wire logic       rx_er,
    input  wire logic [9:0] rxd,
    input  wire logic       crs_comma,
    input  wire logic       col
);
    logic mii;
    logic alt;
    logic tbi;
    logic [1:0] settle_reg;
    assign mii = (interface_select_straps_in == PMTM_SEL_MII);
    assign alt = (interface_select_straps_in == PMTM_SEL_MII_ALT);
    assign tbi = (interface_select_straps_in == PMTM_SEL_TBI);

    // The receive clocks follow the caught mode only from the second edge after reset.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            settle_reg <= 2'h0;
        end else if (settle_reg != 2'h3) begin
            settle_reg <= settle_reg + 2'h1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    a_rx_upper_low: assert property ((mii || alt) |-> rxd[9:4] == 6'h00)
        else $error("upper receive bits not low in nibble mode");
    a_tx_upper_fixed: assert property ((mii || alt) |-> $stable(txd[9:4]))
        else $error("upper transmit bits moved in nibble mode");
    a_alt_gtx_runs: assert property (alt && !gtx_clk |-> ##[1:10] gtx_clk)
        else $error("alternate transmit clock not running");
    a_mii_txclk_runs: assert property (mii && !tx_clk |-> ##[1:10] tx_clk)
        else $error("nibble transmit clock not running");
    a_mii_rxclk_half: assert property ((mii || alt) && rx_clk0 |-> ##[1:8] !rx_clk0)
        else $error("nibble receive clock high too long");
    a_mii_gtx_low: assert property (mii |-> !gtx_clk)
        else $error("gigabit transmit clock not low in standard nibble mode");
    a_tbi_clk_antiphase: assert property (tbi && settle_reg[1] |-> rx_clk0 != rx_clk1)
        else $error("ten-bit receive clocks not in antiphase");
    a_tbi_rx_rate: assert property (tbi && rx_clk0 |=> !rx_clk0)
        else $error("ten-bit receive clock half period wrong");
    a_col_needs_crs: assert property ((mii || alt) && col |-> crs_comma)
        else $error("collision without receive carrier");

    c_mii_rx: cover property (mii && rx_dv);
    c_tbi_comma: cover property (tbi && crs_comma);
    c_col: cover property (col && tx_en);
    c_alt_tx: cover property (alt && tx_en && !tx_er);
endmodule : pmtm_props

// *** tb.sv ***
// Testbench joining both port ends through the interface, one task per scenario.
// Assumes the package constants and a 40 MHz system clock.
`timescale 1ns/10ps
module tb;
    import pmtm_pkg::*;
    logic       clk_in = 1'b0;
    logic       resetn_in = 1'b0;
    logic [2:0] straps = PMTM_SEL_MII;
    logic       speed_100 = 1'b1, half_dup = 1'b0, crs_tx = 1'b0, gig_link = 1'b0;
    logic       lrx_valid = 1'b0, lrx_err = 1'b0, lrx_busy = 1'b0, ltx_ready = 1'b1;
    logic       tx_valid = 1'b0, tx_err = 1'b0;
    logic [9:0] lrx_data = 10'h000, tx_data = 10'h000;
    logic       lrx_ready, ltx_valid, ltx_err, ltx_busy, tx_ready, rx_valid, rx_err, crs, col;
    logic [9:0] ltx_data, rx_data;
    logic [1:0] mode;
    int         n_mismatch = 0, n_compared = 0, n_col = 0, n_crs = 0, n_cc = 0, n_bsy = 0;

    pmtm_if pmtm_if_i ();
    pmtm_dev #(.FIFO_DEPTH(PMTM_FIFO_DEPTH)) pmtm_dev_i (
        .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(1'b1), .interface_select_straps_in(straps),
        .speed_100_in(speed_100), .half_duplex_in(half_dup), .crs_on_tx_in(crs_tx),
        .line_rx_valid_in(lrx_valid), .line_rx_err_in(lrx_err), .line_rx_data_in(lrx_data),
        .line_rx_busy_in(lrx_busy), .line_rx_ready_out(lrx_ready), .line_tx_valid_out(ltx_valid),
        .line_tx_err_out(ltx_err), .line_tx_data_out(ltx_data), .line_tx_ready_in(ltx_ready),
        .line_tx_busy_out(ltx_busy), .mode_out(mode), .port(pmtm_if_i.dev));
    pmtm_mac pmtm_mac_i (
        .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(1'b1), .interface_select_straps_in(straps),
        .speed_100_in(speed_100), .gig_link_in(gig_link), .tx_valid_in(tx_valid), .tx_err_in(tx_err),
        .tx_data_in(tx_data), .tx_ready_out(tx_ready), .rx_valid_out(rx_valid), .rx_err_out(rx_err),
        .rx_data_out(rx_data), .crs_out(crs), .col_out(col), .port(pmtm_if_i.mac));
    pmtm_props pmtm_props_i (
        .clk_in(clk_in), .resetn_in(resetn_in), .interface_select_straps_in(straps),
        .tx_clk(pmtm_if_i.tx_clk), .gtx_clk(pmtm_if_i.gtx_clk), .tx_en(pmtm_if_i.tx_en),
        .tx_er(pmtm_if_i.tx_er), .txd(pmtm_if_i.txd), .rx_clk0(pmtm_if_i.rx_clk0),
        .rx_clk1(pmtm_if_i.rx_clk1), .rx_dv(pmtm_if_i.rx_dv), .rx_er(pmtm_if_i.rx_er),
        .rxd(pmtm_if_i.rxd), .crs_comma(pmtm_if_i.crs_comma), .col(pmtm_if_i.col));

    initial begin
        forever #12.5 clk_in = ~clk_in;
    end

    // Event counters let a scenario see a level that came and went.
    always @(posedge clk_in) begin
        if (col === 1'b1) n_col <= n_col + 1;
        if (crs === 1'b1) n_crs <= n_crs + 1;
        if (pmtm_if_i.crs_comma === 1'b1) n_cc <= n_cc + 1;
        if (ltx_busy === 1'b1) n_bsy <= n_bsy + 1;
    end

    task automatic check(input string name, input logic [9:0] exp, input logic [9:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic do_reset(input logic [2:0] s, input logic sp, input logic [1:0] m);
        resetn_in <= 1'b0;
        straps <= s;
        speed_100 <= sp;
        repeat (6) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        check("mode", {8'h00, m}, {8'h00, mode});
    endtask : do_reset

    task automatic line_send(input logic [9:0] d, input logic e);
        int n = 0;
        lrx_valid <= 1'b1;
        lrx_data <= d;
        lrx_err <= e;
        do @(posedge clk_in); while (lrx_ready !== 1'b1 && ++n < 400);
        lrx_valid <= 1'b0;
    endtask : line_send

    task automatic mac_send(input logic [9:0] d, input logic e);
        int n = 0;
        tx_valid <= 1'b1;
        tx_data <= d;
        tx_err <= e;
        do @(posedge clk_in); while (tx_ready !== 1'b1 && ++n < 400);
        tx_valid <= 1'b0;
        // One idle edge keeps a following call from driving valid twice in one step.
        @(posedge clk_in);
    endtask : mac_send

    task automatic mac_recv(input logic [9:0] d, input logic e);
        int n = 0;
        do @(posedge clk_in); while (rx_valid !== 1'b1 && ++n < 400);
        check("rx_data", d, rx_data);
        check("rx_err", {9'h000, e}, {9'h000, rx_err});
    endtask : mac_recv

    task automatic line_recv(input logic [9:0] d, input logic e);
        int n = 0;
        do @(posedge clk_in); while (ltx_valid !== 1'b1 && ++n < 400);
        check("tx_data", d, ltx_data);
        check("tx_err", {9'h000, e}, {9'h000, ltx_err});
    endtask : line_recv

    task automatic t_mii_rx();
        do_reset(PMTM_SEL_MII, 1'b0, 2'h0);
        line_send(10'h3a5, 1'b0);
        mac_recv(10'h005, 1'b0);
        line_send(10'h0fc, 1'b1);
        mac_recv(10'h00c, 1'b1);
    endtask : t_mii_rx

    task automatic t_mii_tx();
        do_reset(PMTM_SEL_MII, 1'b1, 2'h0);
        mac_send(10'h3c7, 1'b1);
        line_recv(10'h007, 1'b1);
        mac_send(10'h009, 1'b0);
        line_recv(10'h009, 1'b0);
    endtask : t_mii_tx

    task automatic t_alt_fifo();
        int n = 0;
        do_reset(PMTM_SEL_MII_ALT, 1'b1, 2'h1);
        ltx_ready <= 1'b0;
        for (int i = 1; i <= 9; i++) mac_send(10'(i), 1'b0);
        repeat (40) @(posedge clk_in);
        ltx_ready <= 1'b1;
        for (int i = 1; i <= 8; i++) line_recv(10'(i), 1'b0);
        repeat (60) @(posedge clk_in) if (ltx_valid === 1'b1) n++;
        check("dropped", 10'h000, 10'(n));
    endtask : t_alt_fifo

    task automatic t_tbi();
        int c0;
        gig_link <= 1'b1;
        do_reset(PMTM_SEL_TBI, 1'b1, 2'h2);
        c0 = n_cc;
        line_send(10'h0fa, 1'b0);
        // Groups stream on every clock; the group already in flight is skipped.
        repeat (2) @(posedge clk_in);
        mac_recv(10'h0fa, 1'b0);
        repeat (10) @(posedge clk_in);
        check("comma", 10'h001, {9'h000, n_cc > c0});
        mac_send(10'h2b5, 1'b0);
        repeat (2) @(posedge clk_in);
        line_recv(10'h2b5, 1'b0);
    endtask : t_tbi

    task automatic t_crs_col();
        int c0, c1;
        half_dup <= 1'b1;
        crs_tx <= 1'b1;
        do_reset(PMTM_SEL_MII, 1'b1, 2'h0);
        c0 = n_crs;
        lrx_busy <= 1'b1;
        repeat (30) @(posedge clk_in);
        check("crs", 10'h001, {9'h000, n_crs > c0});
        c0 = n_col;
        c1 = n_bsy;
        mac_send(10'h005, 1'b0);
        repeat (30) @(posedge clk_in);
        check("col", 10'h001, {9'h000, n_col > c0});
        check("tx_busy", 10'h001, {9'h000, n_bsy > c1});
        lrx_busy <= 1'b0;
        repeat (30) @(posedge clk_in);
        c0 = n_crs;
        mac_send(10'h006, 1'b0);
        repeat (30) @(posedge clk_in);
        check("crs_tx", 10'h001, {9'h000, n_crs > c0});
        // A strap change while running must leave the caught mode alone.
        straps <= 3'h7;
        repeat (4) @(posedge clk_in);
        check("mode_hold", 10'h000, {8'h00, mode});
    endtask : t_crs_col

    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    initial begin
        t_mii_rx();
        t_mii_tx();
        t_alt_fifo();
        t_tbi();
        t_crs_col();
        print_verdict();
    end

    initial begin
        repeat (60000) @(posedge clk_in);
        n_mismatch++;
        print_verdict();
    end
endmodule : tb
